/* hdl/addr_stack.sv */
// Circular return-address stack for subroutine entry and exit.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_flow_defines.svh"

module addr_stack
	import cpu_flow_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        srst,
	input  wire logic        push,
	input  wire logic        pop,
	input  wire logic [13:0] push_addr,
	output logic      [13:0] top_addr
);

	stack_state_t st;
	stack_state_t next_st;

	// The pointer wraps, so nesting past the depth overwrites the oldest entry silently.
	always_comb begin
		next_st = st;
		if (push) begin
			next_st.slots[st.ptr] = push_addr;
			next_st.ptr           = st.ptr + 3'h1;
		end else if (pop) begin
			next_st.ptr = st.ptr - 3'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Top of stack is the last entry pushed.
	assign top_addr = st.slots[st.ptr - 3'h1];

endmodule // addr_stack
`default_nettype wire

/* hdl/cpu_flow_defines.svh */
// Constant definitions for the control-flow executor: opcodes, fields and sizes.
`ifndef CPU_FLOW_DEFINES_SVH
`define CPU_FLOW_DEFINES_SVH

// Address and stack geometry.
`define PC_W            14
`define PC_RESET        14'h0000
`define STACK_DEPTH     8
`define STACK_PTR_W     3

// Opcode class sits in bits 7..5 of the first byte.
`define CLASS_MISC      3'h0
`define CLASS_BRANCH    3'h1
`define CLASS_ENTRY     3'h2
`define CLASS_EXIT      3'h3
`define CLASS_PORT_RD   3'h4
`define CLASS_PORT_WR   3'h5
`define CLASS_INCDEC    3'h6
`define CLASS_RESTART   3'h7

// Single opcodes of the miscellaneous class.
`define OP_STOP         8'h00
`define OP_HI_IMM       8'h01
`define OP_LO_IMM       8'h02

// Field positions inside the first byte.
`define COND_EN_BIT     3
`define COND_SENSE_BIT  0
`define DEC_BIT         3
`define PORT_RD_MAX     5'h07
`define PORT_WR_MIN     5'h08
`define PORT_WR_MAX     5'h1f
`define RESTART_SHIFT   3

// Condition selector values (bits 2..1).
`define COND_CARRY      2'h0
`define COND_ZERO       2'h1
`define COND_PARITY     2'h2
`define COND_SIGN       2'h3

// Register file indices.
`define REG_A           3'h0
`define REG_B           3'h1
`define REG_H           3'h5
`define REG_L           3'h6

`endif

/* hdl/cpu_flow_exec.sv */
// Instruction executor for branch, subroutine, port, increment, stop and restart operations.
//
// Contract
// [RULE_01] Subroutine entry is three bytes; bytes two and three give the target.
// [RULE_02] Conditional entry happens only if its carry, zero, parity or sign test holds.
// [RULE_03] Subroutine exit resumes at the entry's first byte address plus three.
// [RULE_04] Branch is three bytes; taken branch loads PC from bytes two and three.
// [RULE_05] Conditional branch taken only when its condition holds, else falls through.
// [RULE_06] Subroutine exit is one byte and returns after the entry instruction.
// [RULE_07] Conditional exit only when its condition holds, else continue in sequence.
// [RULE_08] Port operation is one byte, moving one byte between accumulator and device.
// [RULE_09] Read devices are 0 to 7, write devices octal 10 to 37.
// [RULE_10] Increment or decrement adds or subtracts one on registers B through L.
// [RULE_11] Increment and decrement update zero, parity, sign; carry stays unchanged.
// [RULE_12] Stop instruction halts all further fetching and execution.
// [RULE_13] Restart with interrupt resumes a stopped processor at operand times eight.
// [RULE_14] Pointer pair load equals two immediate loads, first H then L.
// [RULE_15] Taken entry pushes return address; taken exit pops it; untaken leaves stack.
// [RULE_16] Parity even means even count of ones; sign minus means top bit set.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_flow_defines.svh"

module cpu_flow_exec
	import cpu_flow_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        srst,
	output logic             mem_req,
	output logic      [13:0] mem_addr,
	input  wire logic  [7:0] mem_rdata,
	input  wire logic        mem_valid,
	input  wire logic        intr_req,
	output logic             intr_ack,
	output port_req_t        port_out,
	input  wire logic  [7:0] port_rdata,
	input  wire logic        port_ack,
	output logic             stopped,
	output logic       [7:0] accumulator,
	output flags_t           flags
);

	cpu_state_t st;
	cpu_state_t next_st;
	logic        stk_push;
	logic        stk_pop;
	logic [13:0] stk_top;
	logic [13:0] ret_addr;

	// The stack must keep the byte after the second operand byte, never the jump target.
	assign ret_addr = st.pc + 14'h1; // [RULE_03]

	// Condition test shared by branch, entry and exit decoding.
	function automatic logic cond_holds(input flags_t f, input logic [7:0] op);
		logic v;
		v = 1'b0;
		case (op[2:1])
			`COND_CARRY:  v = f.carry;
			`COND_ZERO:   v = f.zero;
			`COND_PARITY: v = f.parity_even;
			`COND_SIGN:   v = f.sign_minus;
			default:      v = 1'b0;
		endcase
		// Unconditional forms ignore the flags entirely.
		return !op[`COND_EN_BIT] || (v == op[`COND_SENSE_BIT]);
	endfunction

	// Whether a first byte needs two more operand bytes.
	function automatic logic is_three_byte(input logic [7:0] op);
		return (op[7:5] == `CLASS_BRANCH) || (op[7:5] == `CLASS_ENTRY);
	endfunction

	// Return address stack; only taken entries and exits move it.
	addr_stack u_stack (
		.sys_clk   (sys_clk),
		.srst      (srst),
		.push      (stk_push),
		.pop       (stk_pop),
		.push_addr (ret_addr),
		.top_addr  (stk_top)
	);

	// Next-state logic for the whole executor.
	always_comb begin
		logic [7:0] op;
		logic [7:0] res;
		logic [2:0] idx;
		op       = mem_rdata;
		res      = 8'h00;
		idx      = 3'h0;
		next_st  = st;
		stk_push = 1'b0;
		stk_pop  = 1'b0;
		case (st.phase)
			PH_FETCH: begin
				if (mem_valid) begin
					next_st.opcode = op;
					next_st.pc     = st.pc + 14'h1;
					idx            = op[2:0];
					if (op == `OP_STOP) begin
						next_st.phase = PH_STOPPED; // [RULE_12]
					end else if (op == `OP_HI_IMM || op == `OP_LO_IMM || is_three_byte(op)) begin
						next_st.phase = PH_OPER_LO; // [RULE_01] [RULE_04] [RULE_14]
					end else begin
						case (op[7:5])
							`CLASS_EXIT: begin
								// One-byte exit; an untaken test just moves on.
								if (cond_holds(st.flags, op)) begin // [RULE_06] [RULE_07]
									next_st.pc = stk_top; // [RULE_03]
									stk_pop    = 1'b1; // [RULE_15]
								end
							end
							`CLASS_PORT_RD: begin
								if (op[4:0] <= `PORT_RD_MAX) begin // [RULE_09]
									next_st.port.req    = 1'b1; // [RULE_08]
									next_st.port.write  = 1'b0;
									next_st.port.device = op[4:0];
									next_st.phase       = PH_PORT;
								end
							end
							`CLASS_PORT_WR: begin
								if (op[4:0] >= `PORT_WR_MIN) begin // [RULE_09]
									next_st.port.req    = 1'b1; // [RULE_08]
									next_st.port.write  = 1'b1;
									next_st.port.device = op[4:0];
									next_st.port.wdata  = st.regs[`REG_A];
									next_st.phase       = PH_PORT;
								end
							end
							`CLASS_INCDEC: begin
								// Only B through L are legal targets; others are no-ops.
								if (idx >= `REG_B && idx <= `REG_L) begin // [RULE_10]
									res = op[`DEC_BIT] ? st.regs[idx] - 8'h01
										: st.regs[idx] + 8'h01;
									next_st.regs[idx]         = res;
									next_st.flags.zero        = (res == 8'h00); // [RULE_11]
									next_st.flags.parity_even = ~^res; // [RULE_16]
									next_st.flags.sign_minus  = res[7]; // [RULE_16]
								end
							end
							`CLASS_RESTART: begin
								next_st.pc = 14'(op[2:0]) << `RESTART_SHIFT; // [RULE_13]
							end
							default: begin
								next_st.phase = PH_FETCH;
							end
						endcase
					end
				end
			end
			PH_OPER_LO: begin
				if (mem_valid) begin
					next_st.pc      = st.pc + 14'h1;
					next_st.oper_lo = mem_rdata;
					// Immediate forms finish here; the pair load is simply two of them.
					if (st.opcode == `OP_HI_IMM) begin
						next_st.regs[`REG_H] = mem_rdata; // [RULE_14]
						next_st.phase        = PH_FETCH;
					end else if (st.opcode == `OP_LO_IMM) begin
						next_st.regs[`REG_L] = mem_rdata; // [RULE_14]
						next_st.phase        = PH_FETCH;
					end else begin
						next_st.phase = PH_OPER_HI;
					end
				end
			end
			PH_OPER_HI: begin
				if (mem_valid) begin
					// The pc after the third byte is the first byte address plus three.
					next_st.pc    = st.pc + 14'h1;
					next_st.phase = PH_FETCH;
					if (cond_holds(st.flags, st.opcode)) begin // [RULE_02] [RULE_05]
						stk_push   = (st.opcode[7:5] == `CLASS_ENTRY); // [RULE_15] [RULE_03]
						next_st.pc = {mem_rdata[5:0], st.oper_lo}; // [RULE_01] [RULE_04]
					end
				end
			end
			PH_PORT: begin
				// Request holds until the device acknowledges the single byte.
				if (port_ack) begin
					next_st.port.req = 1'b0;
					next_st.phase    = PH_FETCH;
					if (!st.port.write) begin
						next_st.regs[`REG_A] = port_rdata; // [RULE_08]
					end
				end
			end
			PH_STOPPED: begin
				if (intr_req) begin
					next_st.phase = PH_INT_FETCH; // [RULE_13]
				end
			end
			PH_INT_FETCH: begin
				// The interrupting party supplies the restart byte on the memory bus.
				if (mem_valid) begin
					if (mem_rdata[7:5] == `CLASS_RESTART) begin
						next_st.pc    = 14'(mem_rdata[2:0]) << `RESTART_SHIFT; // [RULE_13]
						next_st.phase = PH_FETCH;
					end else begin
						next_st.phase = PH_STOPPED; // [RULE_12]
					end
				end
			end
			default: begin
				next_st.phase = PH_FETCH;
			end
		endcase
	end

	// State register.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st       <= '0;
			st.phase <= PH_FETCH;
			st.pc    <= `PC_RESET;
		end else begin
			st <= next_st;
		end
	end

	// Bus requests follow the phase; data outputs all come from the state register.
	assign mem_req     = (st.phase == PH_FETCH) || (st.phase == PH_OPER_LO)
		|| (st.phase == PH_OPER_HI) || (st.phase == PH_INT_FETCH);
	assign mem_addr    = st.pc;
	assign intr_ack    = (st.phase == PH_INT_FETCH);
	assign port_out    = st.port;
	assign stopped     = (st.phase == PH_STOPPED); // [RULE_12]
	assign accumulator = st.regs[`REG_A];
	assign flags       = st.flags;

endmodule // cpu_flow_exec
`default_nettype wire

/* hdl/cpu_flow_pkg.sv */
// Types shared by the control-flow executor and its address stack.
package cpu_flow_pkg;

	typedef enum logic [2:0] {
		PH_FETCH,
		PH_OPER_LO,
		PH_OPER_HI,
		PH_PORT,
		PH_STOPPED,
		PH_INT_FETCH
	} phase_t;

	typedef struct packed {
		logic carry;
		logic zero;
		logic parity_even;
		logic sign_minus;
	} flags_t;

	typedef struct packed {
		logic       req;
		logic       write;
		logic [4:0] device;
		logic [7:0] wdata;
	} port_req_t;

	typedef struct packed {
		logic [7:0][13:0] slots;
		logic [2:0]       ptr;
	} stack_state_t;

	typedef struct packed {
		phase_t          phase;
		logic [13:0]     pc;
		logic [7:0]      opcode;
		logic [7:0]      oper_lo;
		logic [7:0][7:0] regs;
		flags_t          flags;
		port_req_t       port;
	} cpu_state_t;

endpackage

/* verification/bus_partner.sv */
// Behavioural program memory and port devices facing the executor.
`timescale 1ns/1ps
`default_nettype none

module bus_partner
	import cpu_flow_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        srst,
	input  wire logic        slow,
	input  wire logic        mem_req,
	input  wire logic [13:0] mem_addr,
	input  wire logic        intr_ack,
	input  wire logic  [7:0] rst_byte,
	input  wire port_req_t   port_out,
	output logic       [7:0] mem_rdata,
	output logic             mem_valid,
	output logic       [7:0] port_rdata,
	output logic             port_ack,
	output logic       [7:0] wr_count,
	output logic       [4:0] wr_dev,
	output logic       [7:0] wr_data
);
	logic [7:0] mem [256];
	logic [7:0] byte_now;
	logic [7:0] dev_byte;

	// Idle lines show the inverse so a stale value never passes for data.
	assign byte_now = intr_ack ? rst_byte : mem[mem_addr[7:0]];
	assign mem_rdata = mem_valid ? byte_now : ~byte_now;
	assign dev_byte = {3'h5, port_out.device};
	assign port_rdata = port_ack ? dev_byte : ~dev_byte;

	// Slow mode leaves a gap cycle between bytes; writes are logged for the bench.
	always_ff @(posedge sys_clk) begin
		mem_valid <= mem_req && !(slow && mem_valid);
		port_ack <= port_out.req && !port_ack;
		if (srst) begin
			wr_count <= 8'h00;
			wr_dev <= 5'h00;
			wr_data <= 8'h00;
		end else if (port_out.req && port_out.write && port_ack) begin
			wr_count <= wr_count + 8'h01;
			wr_dev <= port_out.device;
			wr_data <= port_out.wdata;
		end
	end
endmodule // bus_partner

`default_nettype wire

/* verification/cpu_flow_exec_checker.sv */
// Port-level assertions for the control-flow executor.
`timescale 1ns/1ps
`default_nettype none

module cpu_flow_checker
	import cpu_flow_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        srst,
	input wire logic        mem_req,
	input wire logic [13:0] mem_addr,
	input wire logic  [7:0] mem_rdata,
	input wire logic        mem_valid,
	input wire logic        intr_req,
	input wire logic        intr_ack,
	input wire port_req_t   port_out,
	input wire logic  [7:0] port_rdata,
	input wire logic        port_ack,
	input wire logic        stopped,
	input wire logic  [7:0] accumulator,
	input wire flags_t      flags
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	// A restart byte accepted during the interrupt fetch.
	sequence restart_take_s;
		intr_ack && mem_req && mem_valid && mem_rdata[7:5] == 3'h7;
	endsequence

	// A port read answered by the device in this cycle.
	sequence read_done_s;
		port_out.req && !port_out.write && port_ack;
	endsequence

	// Reset is watched on its own, so it must not be disabled by itself.
	reset_fetch_a: assert property (disable iff (1'b0)
		srst |=> mem_addr == 14'h0000 && !stopped)
		else $error("fetch does not start at zero after reset");
	carry_kept_a: assert property (1 |=> $stable(flags.carry))
		else $error("carry changed");
	read_range_a: assert property (port_out.req && !port_out.write |->
		port_out.device <= 5'h07)
		else $error("read device out of range");
	write_range_a: assert property (port_out.req && port_out.write |->
		port_out.device >= 5'h08)
		else $error("write device out of range");
	port_hold_a: assert property (port_out.req && !port_ack |=>
		port_out.req && $stable(port_out))
		else $error("port request not held");
	read_load_a: assert property (read_done_s |=> accumulator == $past(port_rdata))
		else $error("read byte not in accumulator");
	write_data_a: assert property (port_out.req && port_out.write |->
		port_out.wdata == accumulator)
		else $error("write byte is not the accumulator");
	stop_quiet_a: assert property (stopped && !intr_req |=>
		stopped && !mem_req && !port_out.req)
		else $error("activity while stopped");
	intr_answer_a: assert property (stopped && intr_req |=> intr_ack && mem_req)
		else $error("interrupt not answered");
	restart_vec_a: assert property (restart_take_s |=>
		mem_addr == {8'h00, $past(mem_rdata[2:0]), 3'h0})
		else $error("restart address wrong");
endmodule // cpu_flow_checker

bind cpu_flow_exec cpu_flow_checker u_chk (.sys_clk, .srst, .mem_req, .mem_addr, .mem_rdata,
	.mem_valid, .intr_req, .intr_ack, .port_out, .port_rdata, .port_ack, .stopped,
	.accumulator, .flags);

`default_nettype wire

/* verification/tb_cpu_control_flow_exec.sv */
// Self-checking bench for the control-flow executor.
`timescale 1ns/1ps
`default_nettype none

module tb_cpu_control_flow_exec
	import cpu_flow_pkg::*;
;
	typedef struct packed {
		logic [7:0] s0;
		logic [7:0] s1;
		flags_t     fl;
	} row_t;

	logic        sys_clk, srst, slow, intr_req, mem_req, mem_valid, intr_ack, port_ack, stopped;
	logic [13:0] mem_addr;
	logic  [7:0] mem_rdata, port_rdata, accumulator, rst_byte, wr_count, wr_data, op;
	logic  [4:0] wr_dev;
	logic        taken;
	port_req_t   port_out;
	flags_t      flags;
	int          errors, checks, c;
	// Setup bytes: no-op, decrement B to ff, then back to zero.
	row_t        rows [3] = '{'{8'h03, 8'h03, 4'h0}, '{8'hc9, 8'h03, 4'h3}, '{8'hc9, 8'hc1, 4'h6}};

	cpu_flow_exec u_dut (.sys_clk, .srst, .mem_req, .mem_addr, .mem_rdata, .mem_valid, .intr_req,
		.intr_ack, .port_out, .port_rdata, .port_ack, .stopped, .accumulator, .flags);
	bus_partner u_mem (.sys_clk, .srst, .slow, .mem_req, .mem_addr, .intr_ack, .rst_byte,
		.port_out, .mem_rdata, .mem_valid, .port_rdata, .port_ack, .wr_count, .wr_dev, .wr_data);

	// Free-running 100 MHz clock.
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Memory is loaded only while reset holds the executor still.
	task automatic hold_reset(input logic [71:0] prog);
		@(posedge sys_clk);
		srst <= 1'b1;
		foreach (u_mem.mem[i]) u_mem.mem[i] = 8'h00;
		for (int i = 0; i < 9; i++) u_mem.mem[i] = prog[71-8*i -: 8];
	endtask

	// A bound on every wait keeps a hung design from stalling the run.
	task automatic wait_for(input int what);
		for (int i = 0; i <= 600; i++) begin
			@(posedge sys_clk);
			#1;
			if (what == 0 && stopped === 1'b1) break;
			if (what == 1 && intr_ack === 1'b1) break;
			if (what == 2 && wr_count === 8'h03) break;
			if (i == 600) begin
				errors++;
				tally_and_finish();
			end
		end
	endtask

	task automatic run_to_stop();
		repeat (6) @(posedge sys_clk);
		srst <= 1'b0;
		wait_for(0);
	endtask

	// Main sequence: reset state, table of conditional transfers, then hand tests.
	initial begin
		srst = 1'b1;
		slow = 1'b0;
		intr_req = 1'b0;
		rst_byte = 8'h00;
		repeat (6) @(posedge sys_clk);
		#1;
		check(16'({mem_req, mem_addr}), 16'h4000);
		check(16'({accumulator, flags}), 16'h0000);
		$display("reset test done");
		for (int r = 0; r < 3; r++) begin
			for (int k = 0; k < 18; k++) begin
				c = k % 9;
				op = (k < 9 ? 8'h20 : 8'h40) | (c < 8 ? 8'(8 + c) : 8'h00);
				taken = c == 8 || rows[r].fl[3 - c / 2] === c[0];
				hold_reset({rows[r].s0, rows[r].s1, op, 48'h0700a800a900});
				run_to_stop();
				check(16'(wr_dev), taken ? 16'h0009 : 16'h0008);
				check(16'(flags), 16'(rows[r].fl));
			end
			$display("row %0d done", r);
		end
		slow <= 1'b1;
		hold_reset(72'h834010_00bf00_000000);
		for (int i = 0; i < 10; i++) u_mem.mem[16+i] = 8'(80'h017f0200c56eb088a760 >> (72 - 8 * i));
		// Vector five writes device 9, then a plain restart in the flow jumps to vector seven.
		u_mem.mem[40] = 8'ha9;
		u_mem.mem[41] = 8'hff;
		u_mem.mem[56] = 8'hb1;
		run_to_stop();
		check(16'({wr_count, wr_data}), 16'h02a3);
		check(16'({accumulator, 3'h0, wr_dev}), 16'ha31f);
		check(16'(flags), 16'h0001);
		$display("subroutine test done");
		repeat (5) @(posedge sys_clk);
		#1;
		check(16'({stopped, mem_req}), 16'h0002);
		@(posedge sys_clk);
		intr_req <= 1'b1;
		rst_byte <= 8'hfd;
		wait_for(1);
		@(posedge sys_clk);
		intr_req <= 1'b0;
		wait_for(2);
		check(16'(wr_dev), 16'h0009);
		wait_for(0);
		check(16'({wr_count, 3'h0, wr_dev}), 16'h0411);
		$display("restart test done");
		tally_and_finish();
	end
endmodule // tb_cpu_control_flow_exec

`default_nettype wire
